// >>> logic/mcr_consts.vh
`ifndef MCR_CONSTS_VH
`define MCR_CONSTS_VH
// Control packet flag value
`define MCR_CTL_FLAG_SET 1'h1
// Control type codes
`define MCR_CT_REG 4'h1
`define MCR_CT_CON 4'h2
`define MCR_CT_PRO 4'h3
`define MCR_CT_BSI 4'h4
`define MCR_CT_FRA 4'h5
`define MCR_CT_CFP 4'h6
`define MCR_CT_ALV 4'h7
`define MCR_CT_MUL 4'h8
`define MCR_CT_PRM 4'h9
`define MCR_CT_SEC 4'hA
// Registration header bit positions (16-bit header word)
`define MCR_REG_NEG_BIT 15
`define MCR_REG_ROAM_BIT 14
`define MCR_SECURITY_PROFILE_CAPABILITY_HI 13
`define MCR_SECURITY_PROFILE_CAPABILITY_LO 12
`define MCR_REG_PA_BIT 8
`define MCR_REG_TIME_HI 2
`define MCR_REG_TIME_LO 0
// Keep-alive base wait in seconds
`define MCR_ALV_BASE_S 32
// Node states
`define MCR_ST_UNREG 2'h0
`define MCR_ST_REG 2'h1
`define MCR_ST_SWITCH 2'h2
// Retry engine states
`define MCR_RS_IDLE 2'h0
`define MCR_RS_WAIT 2'h1
`define MCR_RS_DONE 2'h2
`define MCR_RS_FAIL 2'h3
// Tick divider: 1 ms at 40 MHz
`define MCR_TICK_NS 1000000
`define MCR_CLK_NS 25
`define MCR_TICK_CYC (`MCR_TICK_NS / `MCR_CLK_NS)
`endif

// >>> logic/mcr_retry_engine.v
`timescale 1ns/100ps
`default_nettype none
`include "mcr_consts.vh"
module mcr_retry_engine (
  input wire core_clk,
  input wire rstn,
  input wire tick,
  input wire start,
  input wire gotReply,
  input wire abort,
  input wire [15:0] retryInterval,
  input wire [3:0] retryLimit,
  output reg resend,
  output reg done,
  output reg fail,
  output reg busy,
  output reg [3:0] retryCount
);
  reg [1:0] state_q;
  reg [15:0] timer_q;

  // Timer, counter and retry decisions
  always @(posedge core_clk) begin
    resend <= 1'b0;
    done <= 1'b0;
    fail <= 1'b0;
    if (!rstn || abort) begin
      state_q <= `MCR_RS_IDLE;
      timer_q <= 16'h0000;
      retryCount <= 4'h0;
      busy <= 1'b0;
    end else begin
      case (state_q)
        `MCR_RS_IDLE: begin
          if (start) begin
            state_q <= `MCR_RS_WAIT;
            timer_q <= retryInterval;
            retryCount <= 4'h0;
            busy <= 1'b1;
          end
        end
        `MCR_RS_WAIT: begin
          if (gotReply) begin
            state_q <= `MCR_RS_IDLE;
            busy <= 1'b0;
            done <= 1'b1;
          end else if (tick) begin
            if (timer_q > 16'h0001) begin
              timer_q <= timer_q - 16'h0001;
            end else if (retryCount + 4'h1 < retryLimit) begin
              retryCount <= retryCount + 4'h1;
              timer_q <= retryInterval;
              resend <= 1'b1;
            end else begin
              retryCount <= retryCount + 4'h1;
              state_q <= `MCR_RS_IDLE;
              busy <= 1'b0;
              fail <= 1'b1;
            end
          end
        end
        default: begin
          state_q <= `MCR_RS_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> logic/mcr_control_engine.v
`timescale 1ns/100ps
`default_nettype none
`include "mcr_consts.vh"
module mcr_control_engine (
  input wire core_clk,
  input wire rstn,
  // Management settings
  input wire [15:0] retryInterval,
  input wire [3:0] retryLimit,
  input wire [7:0] missedBeaconLimit,
  // Beacon timing
  input wire beaconSlot,
  input wire beaconSeen,
  input wire switchMode,
  // Received PDU
  input wire rxValid,
  input wire rxControlFlag,
  input wire [3:0] rxControlType,
  input wire rxIsReply,
  input wire [7:0] rxTransId,
  // Requester side
  input wire reqStart,
  input wire [3:0] reqControlType,
  input wire reqNeedsReply,
  input wire reqThreeMsg,
  // Registration fill
  input wire [7:0] switchIdIn,
  input wire [13:0] nodeIdIn,
  input wire pathAggregates,
  input wire regNegative,
  input wire regRoaming,
  input wire [1:0] securityCap,
  input wire [2:0] keepAliveExp,
  input wire regRespSel,
  // Join done
  input wire joined,
  // Outputs
  output reg txSend,
  output reg txControlFlag,
  output reg [3:0] txControlType,
  output reg txIsReply,
  output reg [7:0] txTransId,
  output reg [15:0] regHeader,
  output reg [7:0] switchIdOut,
  output reg [13:0] nodeIdOut,
  output reg rxCtlValid,
  output reg [3:0] rxCtlType,
  output reg rxNewRequest,
  output reg linkLost,
  output reg beaconTxEnable,
  output reg closeAllConns,
  output reg searching,
  output reg [1:0] nodeState,
  output reg reqDone,
  output reg reqFail,
  output reg reqBusy,
  output reg [3:0] reqRetryCount,
  output reg respBusy
);
  ////////////////////////////////////////////////////////////////////////
  reg [15:0] tickCnt_q;
  reg tick_q;
  reg [7:0] missCnt_q;
  reg [7:0] lastRxId_q;
  reg lastRxIdValid_q;
  reg [7:0] reqId_q;
  reg [3:0] reqType_q;
  reg respType_q;
  reg [3:0] respCtype_q;
  reg [7:0] respId_q;
  wire reqResend;
  wire reqDoneW;
  wire reqFailW;
  wire reqBusyW;
  wire [3:0] reqCntW;
  wire respResend;
  wire respBusyW;
  wire ctlIn;
  wire isReply;
  wire isRequest;
  wire isRepeat;
  wire listed;
  wire reqGo;
  wire respGo;
  wire lossNow;

  assign ctlIn = rxValid && (rxControlFlag == `MCR_CTL_FLAG_SET);
  assign isReply = ctlIn && rxIsReply;
  assign isRequest = ctlIn && !rxIsReply;
  assign isRepeat = isRequest && lastRxIdValid_q && (rxTransId == lastRxId_q);
  assign listed = (reqControlType == `MCR_CT_CON) ||
                  (reqControlType == `MCR_CT_REG) ||
                  (reqControlType == `MCR_CT_PRO) ||
                  (reqControlType == `MCR_CT_BSI) ||
                  (reqControlType == `MCR_CT_MUL);
  assign reqGo = reqStart && reqNeedsReply && listed && !reqBusyW;
  assign respGo = isRequest && !isRepeat && reqThreeMsg && !respBusyW;
  assign lossNow = beaconSlot && !beaconSeen &&
                   (missCnt_q + 8'h01 >= missedBeaconLimit) &&
                   (nodeState != `MCR_ST_UNREG);

  ////////////////////////////////////////////////////////////////////////
  // Millisecond tick divider
  always @(posedge core_clk) begin
    if (!rstn) begin
      tickCnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end else if (tickCnt_q == `MCR_TICK_CYC - 1) begin
      tickCnt_q <= 16'h0000;
      tick_q <= 1'b1;
    end else begin
      tickCnt_q <= tickCnt_q + 16'h0001;
      tick_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // requester own engine
  mcr_retry_engine reqEngine (
    .core_clk(core_clk),
    .rstn(rstn),
    .tick(tick_q),
    .start(reqGo),
    .gotReply(isReply && reqBusyW && rxTransId == reqId_q),
    .abort(lossNow),
    .retryInterval(retryInterval),
    .retryLimit(retryLimit),
    .resend(reqResend),
    .done(reqDoneW),
    .fail(reqFailW),
    .busy(reqBusyW),
    .retryCount(reqCntW)
  );

  mcr_retry_engine respEngine (
    .core_clk(core_clk),
    .rstn(rstn),
    .tick(tick_q),
    .start(respGo),
    .gotReply(isReply && respBusyW && rxTransId == respId_q),
    .abort(lossNow),
    .retryInterval(retryInterval),
    .retryLimit(retryLimit),
    .resend(respResend),
    .done(),
    .fail(),
    .busy(respBusyW),
    .retryCount()
  );

  ////////////////////////////////////////////////////////////////////////
  // Beacon miss counter and node state
  always @(posedge core_clk) begin
    closeAllConns <= 1'b0;
    linkLost <= 1'b0;
    if (!rstn) begin
      missCnt_q <= 8'h00;
      nodeState <= `MCR_ST_UNREG;
      beaconTxEnable <= 1'b0;
      searching <= 1'b1;
    end else if (lossNow) begin
      missCnt_q <= 8'h00;
      linkLost <= 1'b1;
      beaconTxEnable <= 1'b0;
      closeAllConns <= 1'b1;
      nodeState <= `MCR_ST_UNREG;
      searching <= 1'b1;
    end else if (reqFailW && nodeState != `MCR_ST_UNREG) begin
      nodeState <= `MCR_ST_UNREG;
      beaconTxEnable <= 1'b0;
      closeAllConns <= 1'b1;
      searching <= 1'b1;
    end else begin
      if (beaconSlot) begin
        missCnt_q <= (beaconSeen || nodeState == `MCR_ST_UNREG) ?
          8'h00 : missCnt_q + 8'h01;
      end
      if (joined && nodeState == `MCR_ST_UNREG) begin
        nodeState <= `MCR_ST_REG;
        searching <= 1'b0;
      end else if (nodeState != `MCR_ST_UNREG) begin
        nodeState <= switchMode ? `MCR_ST_SWITCH : `MCR_ST_REG;
        beaconTxEnable <= switchMode;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive decode and duplicate memory
  always @(posedge core_clk) begin
    if (!rstn) begin
      rxCtlValid <= 1'b0;
      rxCtlType <= 4'h0;
      rxNewRequest <= 1'b0;
      lastRxId_q <= 8'h00;
      lastRxIdValid_q <= 1'b0;
    end else begin
      rxCtlValid <= ctlIn;
      rxCtlType <= rxControlType;
      rxNewRequest <= isRequest && !isRepeat;
      if (isRequest) begin
        lastRxId_q <= rxTransId;
        lastRxIdValid_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transaction bookkeeping
  always @(posedge core_clk) begin
    if (!rstn) begin
      reqId_q <= 8'h00;
      reqType_q <= 4'h0;
      respCtype_q <= 4'h0;
      respId_q <= 8'h00;
      respType_q <= 1'b0;
    end else begin
      if (reqGo) begin
        reqId_q <= reqId_q + 8'h01;
        reqType_q <= reqControlType;
      end
      if (isRequest) begin
        respCtype_q <= rxControlType;
        respId_q <= rxTransId;
        respType_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmit request, priority: reply, first send, resends
  always @(posedge core_clk) begin
    if (!rstn) begin
      txSend <= 1'b0;
      txControlFlag <= 1'b0;
      txControlType <= 4'h0;
      txIsReply <= 1'b0;
      txTransId <= 8'h00;
    end else begin
      txSend <= 1'b0;
      txControlFlag <= `MCR_CTL_FLAG_SET;
      if (isRequest) begin
        txSend <= 1'b1;
        txIsReply <= 1'b1;
        txControlType <= rxControlType;
        txTransId <= rxTransId;
      end else if (reqGo) begin
        txSend <= 1'b1;
        txIsReply <= 1'b0;
        txControlType <= reqControlType;
        txTransId <= reqId_q + 8'h01;
      end else if (reqResend) begin
        txSend <= 1'b1;
        txIsReply <= 1'b0;
        txControlType <= reqType_q;
        txTransId <= reqId_q;
      end else if (respResend && respType_q) begin
        txSend <= 1'b1;
        txIsReply <= 1'b1;
        txControlType <= respCtype_q;
        txTransId <= respId_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status outputs
  always @(posedge core_clk) begin
    if (!rstn) begin
      reqDone <= 1'b0;
      reqFail <= 1'b0;
      reqBusy <= 1'b0;
      reqRetryCount <= 4'h0;
      respBusy <= 1'b0;
    end else begin
      reqDone <= reqDoneW;
      reqFail <= reqFailW;
      reqBusy <= reqBusyW;
      reqRetryCount <= reqCntW;
      respBusy <= respBusyW;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registration header fill
  always @(posedge core_clk) begin
    if (!rstn) begin
      regHeader <= 16'h0000;
      switchIdOut <= 8'h00;
      nodeIdOut <= 14'h0000;
    end else begin
      regHeader <= 16'h0000;
      regHeader[`MCR_REG_NEG_BIT] <= regNegative;
      regHeader[`MCR_SECURITY_PROFILE_CAPABILITY_HI:`MCR_SECURITY_PROFILE_CAPABILITY_LO] <= securityCap;
      regHeader[`MCR_REG_ROAM_BIT] <= regRoaming;
      regHeader[`MCR_REG_PA_BIT] <= regRespSel && pathAggregates;
      regHeader[`MCR_REG_TIME_HI:`MCR_REG_TIME_LO] <=
        regRespSel ? keepAliveExp : 3'h0;
      switchIdOut <= switchIdIn;
      nodeIdOut <= nodeIdIn;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/mcr_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module mcr_assertions (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic rxValid,
  input wire logic rxControlFlag,
  input wire logic [3:0] rxControlType,
  input wire logic rxIsReply,
  input wire logic [7:0] rxTransId,
  input wire logic reqStart,
  input wire logic [3:0] reqControlType,
  input wire logic reqNeedsReply,
  input wire logic regNegative,
  input wire logic regRoaming,
  input wire logic [1:0] securityCap,
  input wire logic [2:0] keepAliveExp,
  input wire logic regRespSel,
  input wire logic txSend,
  input wire logic txControlFlag,
  input wire logic txIsReply,
  input wire logic [7:0] txTransId,
  input wire logic [15:0] regHeader,
  input wire logic rxCtlValid,
  input wire logic [3:0] rxCtlType,
  input wire logic linkLost,
  input wire logic beaconTxEnable,
  input wire logic closeAllConns,
  input wire logic searching,
  input wire logic [1:0] nodeState,
  input wire logic reqDone,
  input wire logic reqFail,
  input wire logic reqBusy,
  input wire logic [3:0] reqRetryCount
);
  logic [7:0] lastId_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Id of the last own request sent
  always @(posedge core_clk) begin
    if (txSend && !txIsReply) begin
      lastId_q <= txTransId;
    end
  end
  sequence reqTaken;
    reqStart && reqNeedsReply && !reqBusy && !(rxValid && !rxIsReply)
      && (reqControlType inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h8});
  endsequence
  sequence reqLaunch;
    txSend && !txIsReply ##1 reqBusy && reqRetryCount == 4'h0;
  endsequence
  req_launch_a: assert property (reqTaken |=> reqLaunch)
    else $error("request launch");
  tx_flag_a: assert property (txSend |-> txControlFlag)
    else $error("control flag");
  rx_decode_a: assert property (rxValid && rxControlFlag |=>
    rxCtlValid && rxCtlType == $past(rxControlType)) else $error("decode");
  reply_echo_a: assert property (rxValid && rxControlFlag && !rxIsReply
    |=> txSend && txIsReply && txTransId == $past(rxTransId))
    else $error("reply echo");
  reply_done_a: assert property (reqBusy && rxValid && rxIsReply
    && rxTransId == lastId_q |-> ##2 reqDone ##1 !reqBusy)
    else $error("reply done");
  late_reply_a: assert property (!reqBusy && !reqStart && rxValid
    && rxIsReply |-> ##2 !reqDone) else $error("late reply");
  fail_ends_a: assert property (reqFail |=> !reqBusy
    && nodeState == 2'h0) else $error("failure end");
  link_loss_a: assert property (linkLost |-> closeAllConns
    && !beaconTxEnable && searching && nodeState == 2'h0)
    else $error("link loss");
  reg_head_a: assert property (1'h1 |=> regHeader[15:12] ==
    $past({regNegative, regRoaming, securityCap})) else $error("header");
  alive_time_a: assert property (1'h1 |=> regHeader[2:0] ==
    ($past(regRespSel) ? $past(keepAliveExp) : 3'h0)) else $error("alive");
endmodule
`default_nettype wire

// >>> testbench/mcr_peer_model.sv
`timescale 1ns/100ps
`default_nettype none
module mcr_peer_model (
  input wire logic core_clk,
  input wire logic txSend,
  input wire logic txIsReply,
  input wire logic [3:0] txControlType,
  input wire logic [7:0] txTransId,
  output logic rxValid,
  output logic rxControlFlag,
  output logic [3:0] rxControlType,
  output logic rxIsReply,
  output logic [7:0] rxTransId
);
  int replyDelay = 0;
  logic [3:0] aType;
  logic [7:0] aId;
  initial begin
    rxValid = 1'h0;
    rxControlFlag = 1'h0;
    rxControlType = 4'h0;
    rxIsReply = 1'h0;
    rxTransId = 8'h00;
  end
  task send(input logic f, input logic [3:0] t, input logic r,
            input logic [7:0] id);
    @(negedge core_clk);
    rxValid = 1'h1;
    {rxControlFlag, rxControlType, rxIsReply, rxTransId} = {f, t, r, id};
    @(negedge core_clk);
    rxValid = 1'h0;
    {rxControlFlag, rxControlType, rxIsReply, rxTransId} = ~{f, t, r, id};
  endtask
  always @(posedge core_clk) begin
    if (replyDelay > 0 && txSend && !txIsReply) begin
      aType = txControlType;
      aId = txTransId;
      repeat (replyDelay) @(posedge core_clk);
      send(1'h1, aType, 1'h1, aId);
    end
  end
endmodule
`default_nettype wire

// >>> testbench/mcr_control_engine_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module mcr_control_engine_tb_top;
  logic core_clk = 1'h0, rstn = 1'h0, beaconSlot = 1'h0, beaconSeen = 1'h0;
  logic [15:0] retryInterval = 16'h0001;
  logic [3:0] retryLimit = 4'h2, reqControlType = 4'h0;
  logic [7:0] missedBeaconLimit = 8'h03, switchIdIn = 8'h5A;
  logic switchMode = 1'h1, reqStart = 1'h0, reqNeedsReply = 1'h1;
  logic reqThreeMsg = 1'h0, pathAggregates = 1'h1, regNegative = 1'h1;
  logic regRoaming = 1'h0, regRespSel = 1'h0, joined = 1'h0;
  logic [13:0] nodeIdIn = 14'h02C3;
  logic [1:0] securityCap = 2'h2;
  logic [2:0] keepAliveExp = 3'h7;
  wire rxValid, rxControlFlag, rxIsReply, txSend, txControlFlag, txIsReply;
  wire [3:0] rxControlType, txControlType, rxCtlType, reqRetryCount;
  wire [7:0] rxTransId, txTransId, switchIdOut;
  wire [15:0] regHeader;
  wire [13:0] nodeIdOut;
  wire [1:0] nodeState;
  wire rxCtlValid, rxNewRequest, linkLost, beaconTxEnable, closeAllConns;
  wire searching, reqDone, reqFail, reqBusy, respBusy;
  int miscompares = 0, total_checks = 0, cyc = 0, k;
  logic [7:0] id;
  mcr_control_engine uut (.*);
  mcr_peer_model peer (.*);
  always #12.5 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task summarize;
    $display("checks=%0d miscompares=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Hang guard
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      miscompares++;
      summarize();
    end
  end
  task tick;
    @(negedge core_clk);
  endtask
  task join_net;
    tick; joined = 1'h1;
    tick; joined = 1'h0;
    tick;
  endtask
  task beacon(input logic s);
    tick; beaconSlot = 1'h1; beaconSeen = s;
    tick; beaconSlot = 1'h0;
  endtask
  task start(input logic [3:0] t);
    tick; reqStart = 1'h1; reqControlType = t;
    tick; reqStart = 1'h0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task t_rx;
    for (int c = 1; c <= 10; c++) begin
      peer.send(1'h1, c[3:0], 1'h0, c[7:0]);
      check({rxCtlValid, rxCtlType}, {1'h1, c[3:0]});
      check({rxNewRequest, txSend, txIsReply}, 3'h7);
    end
    peer.send(1'h1, 4'hA, 1'h0, 8'h0A);
    check({rxNewRequest, txSend, txTransId}, 10'h10A);
    peer.send(1'h0, 4'h2, 1'h0, 8'h33);
    check({rxCtlValid, txSend}, 2'h0);
  endtask
  task t_reg;
    tick; tick;
    check(regHeader[15:12], 4'hA);
    check(regHeader[2:0], 3'h0);
    check({switchIdOut, nodeIdOut}, {8'h5A, 14'h02C3});
    check(regHeader[8], 1'h0);
    regRespSel = 1'h1; regRoaming = 1'h1; regNegative = 1'h0;
    tick; tick;
    check(regHeader[15:12], 4'h6);
    check({regHeader[8], regHeader[2:0]}, 4'hF);
    pathAggregates = 1'h0;
    tick; tick;
    check(regHeader[8], 1'h0);
  endtask
  task t_link;
    join_net;
    check({beaconTxEnable, nodeState != 2'h0}, 2'h3);
    beacon(1'h0); beacon(1'h0); beacon(1'h1); beacon(1'h0); beacon(1'h0);
    check(linkLost, 1'h0);
    beacon(1'h0);
    check({linkLost, closeAllConns, beaconTxEnable, searching, nodeState},
          6'h34);
  endtask
  task t_ok;
    join_net;
    start(4'h2);
    check({txSend, txIsReply, txControlType}, 6'h22);
    id = txTransId;
    tick;
    check({reqBusy, reqRetryCount}, 5'h10);
    peer.send(1'h1, 4'h2, 1'h1, id);
    tick;
    check(reqDone, 1'h1);
    tick;
    check(reqBusy, 1'h0);
    peer.send(1'h1, 4'h2, 1'h1, id);
    tick;
    check({reqDone, reqFail, reqBusy}, 3'h0);
    start(4'h7);
    check(txSend, 1'h0);
    tick;
    check(reqBusy, 1'h0);
  endtask
  task t_retry;
    start(4'h8);
    id = txTransId;
    tick;
    peer.replyDelay = 3;
    for (k = 0; k < 41000 && txSend !== 1'h1; k++) tick;
    check({txSend, txIsReply, txTransId}, {2'h2, id});
    tick;
    check(reqRetryCount, 4'h1);
    for (k = 0; k < 20 && reqDone !== 1'h1; k++) tick;
    check(reqDone, 1'h1);
    peer.replyDelay = 0;
  endtask
  task t_three;
    reqThreeMsg = 1'h1;
    peer.send(1'h1, 4'h3, 1'h0, 8'h40);
    check({rxNewRequest, txSend, txIsReply}, 3'h7);
    tick;
    check(respBusy, 1'h1);
    peer.send(1'h1, 4'h3, 1'h1, 8'h40);
    tick;
    check(respBusy, 1'h0);
    reqThreeMsg = 1'h0;
  endtask
  task t_fail;
    join_net;
    retryLimit = 4'h1;
    start(4'h4);
    for (k = 0; k < 41000 && reqFail !== 1'h1; k++) tick;
    check(reqFail, 1'h1);
    tick;
    check({reqBusy, nodeState}, 3'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) tick;
    rstn = 1'h1;
    tick;
    check({searching, nodeState, reqBusy, linkLost}, 5'h10);
    t_rx;
    t_reg;
    t_link;
    t_ok;
    t_three;
    t_retry;
    t_fail;
    summarize();
  end
endmodule
bind mcr_control_engine mcr_assertions chk (.*);
`default_nettype wire
